// [include/fault_pkg.sv]
// package: constants, types and register map of the supply fault response block
package fault_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 10000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [8:0] TICK_LAST = 9'(TICK_CYCLES - 1);

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RESP_BASE = 8'h04;
  localparam logic [7:0] OFS_TON_LIMIT = 8'h18;
  localparam logic [7:0] OFS_RETRY_DELAY = 8'h1C;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h20;
  localparam logic [7:0] OFS_STATUS_DETAIL = 8'h24;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2C;
  localparam logic [7:0] OFS_CHAN_STATE = 8'h30;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int NUM_SRC = 5;
  localparam logic [2:0] SRC_HOT = 3'h0;
  localparam logic [2:0] SRC_COLD = 3'h1;
  localparam logic [2:0] SRC_VIN_OV = 3'h2;
  localparam logic [2:0] SRC_VIN_UV = 3'h3;
  localparam logic [2:0] SRC_TON = 3'h4;
  localparam int ACT_HI = 7;
  localparam int ACT_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam logic [7:0] RESP_RESET = 8'h00;
  localparam logic [7:0] RESP_STORED_MASK = 8'hF8;
  localparam logic [15:0] TON_LIMIT_RESET = 16'h000A;
  localparam logic [15:0] RETRY_DELAY_RESET = 16'h000A;
  localparam logic [0:0] CTRL_ON_RESET = 1'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // status word bits
  localparam int SW_VOUT = 15;
  localparam int SW_INPUT = 13;
  localparam int SW_OFF = 6;
  localparam int SW_VIN_UV = 3;
  localparam int SW_TEMP = 2;
  localparam int SW_HIGH_BYTE = 0;
  // detail bits: vout timeout, input and temperature over / under
  localparam int SV_TON_MAX = 2;
  localparam int SD_OVER = 7;
  localparam int SD_UNDER = 4;

  // interrupt event bits
  localparam int IRQ_MEAS = 0;
  localparam int IRQ_TON = 1;
  localparam int IRQ_SHUT = 2;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_RAMP = 3'b001,
    ST_ON = 3'b010,
    ST_RETRY = 3'b011,
    ST_LATCHED = 3'b100
  } chan_state_t;

  // one converter result with its limit comparisons
  typedef struct packed {
    logic valid;
    logic hot;
    logic cold;
    logic vin_ov;
    logic vin_uv;
  } conv_t;

endpackage

// [design/tick_timer.sv]
// 10 us timebase, restartable from the shared timebase pin
module tick_timer
  import fault_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic sync_pin_i,
  output logic tick_o
);

  logic [8:0] cnt_reg, cnt_next;
  logic pin_reg, pin_next;
  logic tick_reg, tick_next;
  logic pin_rise;

  // count down one period; a rising pin edge realigns every timer in the system
  always_comb begin
    pin_rise = sync_pin_i & ~pin_reg;
    pin_next = sync_pin_i;
    tick_next = 1'b0;
    cnt_next = cnt_reg - 9'h001;
    if (pin_rise || cnt_reg == 9'h000) begin
      tick_next = 1'b1;
      cnt_next = TICK_LAST;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 9'h000;
      pin_reg <= 1'b0;
      tick_reg <= 1'b0;
    end else if (ce_i) begin
      cnt_reg <= cnt_next;
      pin_reg <= pin_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule

// [design/supply_fault_response_control.sv]
// fault response control: measured and turn-on timeout faults, status, alert
module supply_fault_response_control
  import fault_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire conv_t conv_i,
  input wire logic channel_on_pin_i,
  input wire logic bias_ok_i,
  input wire logic power_good_i,
  input wire logic shared_timebase_pin_i,
  output logic channel_enable_o,
  output logic host_alert_n_o,
  output logic irq_o
);

  // ****************************************
  // state
  // ****************************************
  logic wr_pend_reg, wr_pend_next;
  logic [7:0] wr_addr_reg, wr_addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic ctrl_on_reg, ctrl_on_next;
  logic [7:0] resp_reg [NUM_SRC];
  logic [7:0] resp_next [NUM_SRC];
  logic [15:0] ton_limit_reg, ton_limit_next;
  logic [15:0] retry_delay_reg, retry_delay_next;
  logic [2:0] irq_mask_reg, irq_mask_next;
  logic [2:0] irq_stat_reg, irq_stat_next;
  logic [15:0] status_word_reg, status_word_next;
  logic [7:0] stat_vout_reg, stat_vout_next;
  logic [7:0] stat_input_reg, stat_input_next;
  logic [7:0] stat_temp_reg, stat_temp_next;
  logic alert_n_reg, alert_n_next;
  logic irq_reg, irq_next;
  chan_state_t state_reg, state_next;
  logic [15:0] tick_cnt_reg, tick_cnt_next;
  logic [2:0] cause_reg, cause_next;
  logic [2:0] snap_retry_reg [NUM_SRC];
  logic [2:0] snap_retry_next [NUM_SRC];
  logic en_reg, en_next;

  logic tick;
  logic rd_take, wr_take, wr_now, clear_faults;
  logic on_cmd, running, ton_fault;
  logic [NUM_SRC-1:0] hit, shut_vec;
  logic [2:0] pick;
  logic [2:0] ev;

  // index of the lowest set bit; several faults in one step share one shutdown
  function automatic logic [2:0] first_set(input logic [NUM_SRC-1:0] v);
    first_set = 3'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  // true once one more tick makes the count reach the limit
  function automatic logic reached(input logic [15:0] cnt, input logic [15:0] lim);
    reached = ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
  endfunction

  tick_timer u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .sync_pin_i(shared_timebase_pin_i),
    .tick_o(tick)
  );

  // ****************************************
  // bus slave
  // ****************************************
  // zero wait states: read data is fetched in the address phase so it can stand registered
  always_comb begin
    rd_take = hsel_i & hready_i & htrans_i[1] & ~hwrite_i;
    wr_take = hsel_i & hready_i & htrans_i[1] & hwrite_i & (hsize_i == 3'b010);
    wr_pend_next = wr_pend_reg ? 1'b0 : wr_take;
    if (wr_take) begin
      wr_pend_next = 1'b1;
    end
    wr_addr_next = wr_take ? {haddr_i[7:2], 2'b00} : wr_addr_reg;
    hrdata_next = hrdata_reg;
    if (rd_take) begin
      hrdata_next = 32'h0000_0000;
      unique case ({haddr_i[7:2], 2'b00})
        OFS_CTRL: hrdata_next[CTRL_ON_BIT] = ctrl_on_reg;
        OFS_TON_LIMIT: hrdata_next[15:0] = ton_limit_reg;
        OFS_RETRY_DELAY: hrdata_next[15:0] = retry_delay_reg;
        OFS_STATUS_WORD: begin
          hrdata_next[15:0] = status_word_reg;
          hrdata_next[SW_OFF] = ~en_reg; // live off bit, not a fault
        end
        OFS_STATUS_DETAIL: hrdata_next[23:0] = {stat_temp_reg, stat_input_reg, stat_vout_reg};
        OFS_IRQ_STATUS: hrdata_next[2:0] = irq_stat_reg;
        OFS_IRQ_MASK: hrdata_next[2:0] = irq_mask_reg;
        OFS_CHAN_STATE: hrdata_next[2:0] = state_reg;
        default: begin
          for (int i = 0; i < NUM_SRC; i++) begin
            if ({haddr_i[7:2], 2'b00} == OFS_RESP_BASE + 8'(4 * i)) begin
              hrdata_next[7:0] = resp_reg[i]; // delay bits are never stored
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      hrdata_reg <= hrdata_next;
    end
  end

  // ****************************************
  // register file
  // ****************************************
  // writes land at the end of the data phase, when hwdata stands
  always_comb begin
    wr_now = wr_pend_reg;
    clear_faults = wr_now & (wr_addr_reg == OFS_CTRL) & hwdata_i[CTRL_CLEAR_BIT];
    ctrl_on_next = ctrl_on_reg;
    ton_limit_next = ton_limit_reg;
    retry_delay_next = retry_delay_reg;
    irq_mask_next = irq_mask_reg;
    for (int i = 0; i < NUM_SRC; i++) begin
      resp_next[i] = resp_reg[i];
      if (wr_now && wr_addr_reg == OFS_RESP_BASE + 8'(4 * i)) begin
        resp_next[i] = hwdata_i[7:0] & RESP_STORED_MASK;
      end
    end
    if (wr_now) begin
      unique case (wr_addr_reg)
        OFS_CTRL: ctrl_on_next = hwdata_i[CTRL_ON_BIT];
        OFS_TON_LIMIT: ton_limit_next = hwdata_i[15:0];
        OFS_RETRY_DELAY: retry_delay_next = hwdata_i[15:0];
        OFS_IRQ_MASK: irq_mask_next = hwdata_i[2:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_on_reg <= CTRL_ON_RESET;
      ton_limit_reg <= TON_LIMIT_RESET;
      retry_delay_reg <= RETRY_DELAY_RESET;
      irq_mask_reg <= IRQ_MASK_RESET;
      for (int i = 0; i < NUM_SRC; i++) begin
        resp_reg[i] <= RESP_RESET;
      end
    end else if (ce_i) begin
      ctrl_on_reg <= ctrl_on_next;
      ton_limit_reg <= ton_limit_next;
      retry_delay_reg <= retry_delay_next;
      irq_mask_reg <= irq_mask_next;
      for (int i = 0; i < NUM_SRC; i++) begin
        resp_reg[i] <= resp_next[i];
      end
    end
  end

  // ****************************************
  // channel sequencer
  // ****************************************
  // any off command (pin, software, bias) wins and also releases a latched shutdown
  always_comb begin
    on_cmd = channel_on_pin_i & ctrl_on_reg & bias_ok_i;
    running = (state_reg == ST_RAMP) | (state_reg == ST_ON);
    ton_fault = (state_reg == ST_RAMP) & tick & ~power_good_i
              & reached(tick_cnt_reg, ton_limit_reg);
    // raw flags straight from the new result, no deglitch
    hit = {ton_fault, conv_i.vin_uv, conv_i.vin_ov, conv_i.cold, conv_i.hot}
        & {1'b1, {4{conv_i.valid}}};
    for (int i = 0; i < NUM_SRC; i++) begin
      shut_vec[i] = hit[i] & (resp_reg[i][ACT_HI:ACT_LO] != 2'b00);
    end
    pick = first_set(shut_vec);
    state_next = state_reg;
    tick_cnt_next = tick_cnt_reg;
    cause_next = cause_reg;
    for (int i = 0; i < NUM_SRC; i++) begin
      snap_retry_next[i] = snap_retry_reg[i];
    end
    unique case (state_reg)
      ST_OFF: begin
        if (on_cmd) begin
          state_next = ST_RAMP;
          tick_cnt_next = 16'h0000;
          for (int i = 0; i < NUM_SRC; i++) begin
            snap_retry_next[i] = resp_reg[i][RETRY_HI:RETRY_LO];
          end
        end
      end
      ST_RAMP, ST_ON: begin
        if (!on_cmd) begin
          state_next = ST_OFF;
        end else if (|shut_vec) begin
          cause_next = pick;
          tick_cnt_next = 16'h0000;
          // zero retry holds the output off
          state_next = (snap_retry_reg[pick] == 3'h0) ? ST_LATCHED : ST_RETRY;
        end else if (state_reg == ST_RAMP) begin
          if (power_good_i || ton_fault) begin
            state_next = ST_ON; // timeout with action 00 keeps going
          end else if (tick) begin
            tick_cnt_next = tick_cnt_reg + 16'h0001;
          end
        end
      end
      ST_RETRY: begin
        if (!on_cmd) begin
          state_next = ST_OFF;
        end else if (|(shut_vec & ~(5'h01 << cause_reg))) begin
          state_next = ST_LATCHED; // a different shutdown fault ends retrying
        end else if (tick) begin
          tick_cnt_next = tick_cnt_reg + 16'h0001;
          if (reached(tick_cnt_reg, retry_delay_reg)) begin
            state_next = ST_RAMP; // endless restarts
            tick_cnt_next = 16'h0000;
          end
        end
      end
      ST_LATCHED: begin
        if (!on_cmd) begin
          state_next = ST_OFF;
        end
      end
      default: state_next = ST_OFF;
    endcase
    en_next = (state_next == ST_RAMP) | (state_next == ST_ON);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= ST_OFF;
      tick_cnt_reg <= 16'h0000;
      cause_reg <= 3'h0;
      en_reg <= 1'b0;
      for (int i = 0; i < NUM_SRC; i++) begin
        snap_retry_reg[i] <= 3'h0;
      end
    end else if (ce_i) begin
      state_reg <= state_next;
      tick_cnt_reg <= tick_cnt_next;
      cause_reg <= cause_next;
      en_reg <= en_next;
      for (int i = 0; i < NUM_SRC; i++) begin
        snap_retry_reg[i] <= snap_retry_next[i];
      end
    end
  end

  // ****************************************
  // status, alert and interrupt
  // ****************************************
  // a fault in the clear cycle survives: set wins over clear
  always_comb begin
    status_word_next = clear_faults ? 16'h0000 : status_word_reg;
    stat_vout_next = clear_faults ? 8'h00 : stat_vout_reg;
    stat_input_next = clear_faults ? 8'h00 : stat_input_reg;
    stat_temp_next = clear_faults ? 8'h00 : stat_temp_reg;
    if (hit[SRC_HOT] || hit[SRC_COLD]) begin
      status_word_next[SW_TEMP] = 1'b1;
    end
    if (hit[SRC_VIN_OV] || hit[SRC_VIN_UV]) begin
      status_word_next[SW_INPUT] = 1'b1;
    end
    if (hit[SRC_VIN_UV]) begin
      status_word_next[SW_VIN_UV] = 1'b1;
    end
    stat_temp_next[SD_OVER] = stat_temp_next[SD_OVER] | hit[SRC_HOT];
    stat_temp_next[SD_UNDER] = stat_temp_next[SD_UNDER] | hit[SRC_COLD];
    stat_input_next[SD_OVER] = stat_input_next[SD_OVER] | hit[SRC_VIN_OV];
    stat_input_next[SD_UNDER] = stat_input_next[SD_UNDER] | hit[SRC_VIN_UV];
    if (hit[SRC_TON]) begin
      status_word_next[SW_VOUT] = 1'b1;
      status_word_next[SW_HIGH_BYTE] = 1'b1;
      stat_vout_next[SV_TON_MAX] = 1'b1;
    end
    // alert follows stored faults only, so clearing them releases it
    alert_n_next = ~(|status_word_next);
    ev = 3'h0;
    ev[IRQ_MEAS] = |hit[3:0];
    ev[IRQ_TON] = hit[SRC_TON];
    ev[IRQ_SHUT] = (running & on_cmd & (|shut_vec)) | (state_next == ST_LATCHED
                 & state_reg == ST_RETRY);
    irq_stat_next = irq_stat_reg;
    if (wr_now && wr_addr_reg == OFS_IRQ_STATUS) begin
      irq_stat_next = irq_stat_reg & ~hwdata_i[2:0];
    end
    irq_stat_next = irq_stat_next | ev;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_word_reg <= 16'h0000;
      stat_vout_reg <= 8'h00;
      stat_input_reg <= 8'h00;
      stat_temp_reg <= 8'h00;
      alert_n_reg <= 1'b1;
      irq_stat_reg <= 3'h0;
      irq_reg <= 1'b0;
    end else if (ce_i) begin
      status_word_reg <= status_word_next;
      stat_vout_reg <= stat_vout_next;
      stat_input_reg <= stat_input_next;
      stat_temp_reg <= stat_temp_next;
      alert_n_reg <= alert_n_next;
      irq_stat_reg <= irq_stat_next;
      irq_reg <= irq_next;
    end
  end

  assign hrdata_o = hrdata_reg;
  assign hreadyout_o = ~rst_i | 1'b1;
  assign hresp_o = 1'b0;
  assign channel_enable_o = en_reg;
  assign host_alert_n_o = alert_n_reg;
  assign irq_o = irq_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_meas_alert_low: assert property (ce_i && conv_i.valid && conv_i.hot |=> !host_alert_n_o)
    else $error("measured fault did not pull alert low");
  a_meas_status_set: assert property (ce_i && conv_i.valid && conv_i.vin_uv
    |=> status_word_reg[SW_VIN_UV] && status_word_reg[SW_INPUT] && stat_input_reg[SD_UNDER])
    else $error("input undervoltage status bits not set");
  a_keep_running: assert property (ce_i && state_reg == ST_ON && on_cmd && hit != 5'h00
    && shut_vec == 5'h00 |=> state_reg == ST_ON && channel_enable_o)
    else $error("action zero fault stopped the channel");
  a_shutdown_now: assert property (ce_i && running && on_cmd && shut_vec != 5'h00
    |=> !channel_enable_o)
    else $error("shutdown fault left the output enabled");
  a_no_retry_latch: assert property (ce_i && running && on_cmd && shut_vec != 5'h00
    && snap_retry_reg[pick] == 3'h0
    |=> state_reg == ST_LATCHED ##1 (state_reg == ST_LATCHED || !$past(on_cmd)))
    else $error("retry zero did not latch the channel off");
  a_latch_holds: assert property (ce_i && state_reg == ST_LATCHED && on_cmd
    |=> state_reg == ST_LATCHED && !channel_enable_o)
    else $error("latched channel came back on");
  a_clear_keeps_off: assert property (ce_i && clear_faults && hit == 5'h00
    && state_reg == ST_LATCHED && on_cmd |=> host_alert_n_o && state_reg == ST_LATCHED)
    else $error("clear faults misbehaved");
  a_ton_status: assert property (ce_i && ton_fault |=> stat_vout_reg[SV_TON_MAX]
    && status_word_reg[SW_VOUT] && status_word_reg[SW_HIGH_BYTE] && !host_alert_n_o)
    else $error("turn-on timeout status or alert missing");
  a_delay_reads_zero: assert property (ce_i && rd_take && haddr_i[7:0] >= OFS_RESP_BASE
    && haddr_i[7:0] < OFS_TON_LIMIT |=> hrdata_o[2:0] == 3'h0)
    else $error("response delay field read nonzero");
  a_count_on_tick: assert property (ce_i && !tick && state_reg == ST_RAMP && on_cmd
    && shut_vec == 5'h00 && !power_good_i |=> $stable(tick_cnt_reg))
    else $error("turn-on timer moved without a tick");
  a_retry_restart: assert property (ce_i && state_reg == ST_RETRY && on_cmd && tick
    && shut_vec == 5'h00 && reached(tick_cnt_reg, retry_delay_reg)
    |=> state_reg == ST_RAMP && channel_enable_o)
    else $error("retry delay expired without restart");

  c_retry_path: cover property (state_reg == ST_RETRY ##1 state_reg == ST_RAMP);
  c_ton_timeout: cover property (ton_fault);
  c_latched: cover property (state_reg == ST_LATCHED);
  c_clear_alert: cover property (!host_alert_n_o ##1 clear_faults ##1 host_alert_n_o);

endmodule

// [test/supply_model.sv]
// partner: supply channel that reports regulation a few cycles after it is enabled
module supply_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic slow_i,
  output logic power_good_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ramp_reg;
  // ramp counter restarts whenever the channel is disabled
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i || !enable_i) ramp_reg <= 4'h0;
    else if (ramp_reg != 4'hF) ramp_reg <= ramp_reg + 4'h1;
  end
  // a slow supply never reaches regulation, like a shorted output
  assign power_good_o = enable_i && !slow_i && (ramp_reg >= 4'h4);
endmodule

// [test/tb_top.sv]
// bench: drives the fault response block over ahb and its pins, checks results
module tb_top import fault_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, hwrite = 0, hready, hresp, pin = 0, bias = 1, slow = 0;
  logic pg, en, alert_n, irq, dph = 0, ce = 1, sync = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0;
  conv_t conv = '0;
  logic [31:0] q[$];
  string nq[$];
  int error_cnt = 0, samples_checked = 0, seed = 42, s;
  logic [1:0] act;
  initial forever #12.5 clk_i = ~clk_i;
  supply_fault_response_control supply_fault_response_control_inst (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(ce), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp), .conv_i(conv),
    .channel_on_pin_i(pin), .bias_ok_i(bias), .power_good_i(pg),
    .shared_timebase_pin_i(sync), .channel_enable_o(en), .host_alert_n_o(alert_n),
    .irq_o(irq));
  supply_model supply_model_inst (.clk_i(clk_i), .rst_i(rst_i), .enable_i(en),
    .slow_i(slow), .power_good_o(pg));
  // ****************************************
  // checking and closing
  // ****************************************
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task results;
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // read data is compared at the data phase edge, oldest note first
  always @(posedge clk_i) begin
    if (dph) chk(nq.pop_front(), hrdata, q.pop_front());
    dph <= htrans[1] & ~hwrite & hready;
  end
  // ****************************************
  // bus and pin tasks
  // ****************************************
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task rdy;
    int n;
    n = 0;
    @(posedge clk_i);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        error_cnt++;
        results;
      end
      @(posedge clk_i);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    rdy;
    htrans <= 2'b00;
    hwdata <= d;
    rdy;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    q.push_back(exp);
    nq.push_back($sformatf("reg %h", a));
    bus(a, 1'b0, 32'h0);
  endtask
  // bounded wait for the channel enable, a timeout counts as a mismatch
  task wait_en(input logic v, input int n);
    for (int i = 0; i < n && en !== v; i++) @(posedge clk_i);
    #1;
    if (en !== v) begin
      error_cnt++;
      $display("wrong value channel enable expected %b seen %b", v, en);
      results;
    end
  endtask
  task start;
    pin <= 1'b1;
    wait_en(1'b1, 20);
    tick(10);
    rd(OFS_CHAN_STATE, 32'h2);
  endtask
  // one converter result; outputs are looked at one cycle after it is taken
  task pulse(input logic [3:0] f);
    conv <= {1'b1, f};
    @(posedge clk_i);
    conv <= '0;
    tick(1);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    rd(OFS_RESP_BASE, 32'h0);
    rd(OFS_TON_LIMIT, 32'h0A);
    rd(OFS_RETRY_DELAY, 32'h0A);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(8'h3C, 32'h0);
    wr(OFS_RESP_BASE + 8'h10, 32'hFF);
    rd(OFS_RESP_BASE + 8'h10, 32'hF8);
    wr(OFS_RESP_BASE + 8'h10, 32'h0);
    wr(OFS_CTRL, 32'h1);
    chk("response", hresp, 32'h0);
    $display("test registers done");
    // shutdown actions 01, 10, 11 on the first three measured sources, a random one on the fourth, retry zero
    for (s = 0; s < 4; s++) begin
      act = (s < 3) ? 2'(s + 1) : 2'(($unsigned($random(seed)) % 3) + 1);
      wr(OFS_RESP_BASE + 8'(4 * s), {24'h0, act, 6'h0});
      start;
      pulse(4'h8 >> s);
      chk("enable", en, 32'h0);
      chk("alert", alert_n, 32'h0);
      rd(OFS_STATUS_DETAIL, 32'h1 << ((s < 2 ? 16 : 8) + (s[0] ? SD_UNDER : SD_OVER)));
      rd(OFS_STATUS_WORD, (s < 2 ? 32'h4 : 32'h2000 | (s == 3 ? 32'h8 : 32'h0)) | 32'h40);
      wr(OFS_CTRL, 32'h3);
      tick(2);
      chk("alert", alert_n, 32'h1);
      rd(OFS_CHAN_STATE, 32'h4);
      pin <= 1'b0;
      tick(3);
      rd(OFS_CHAN_STATE, 32'h0);
      wr(OFS_RESP_BASE + 8'(4 * s), 32'h0);
    end
    $display("test shutdown actions done");
    // action 00 keeps running; interrupt raised, cleared and masked
    wr(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_IRQ_MASK, 32'h1);
    start;
    chk("irq", irq, 32'h0);
    pulse(4'h1);
    chk("enable", en, 32'h1);
    chk("alert", alert_n, 32'h0);
    chk("irq", irq, 32'h1);
    rd(OFS_STATUS_WORD, 32'h2008);
    wr(OFS_IRQ_STATUS, 32'h1);
    tick(2);
    chk("irq", irq, 32'h0);
    wr(OFS_IRQ_MASK, 32'h0);
    pulse(4'h8);
    chk("irq", irq, 32'h0);
    rd(OFS_IRQ_STATUS, 32'h1);
    wr(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_CTRL, 32'h3);
    // clock enable low freezes the channel although the pin has dropped
    ce <= 1'b0;
    pin <= 1'b0;
    tick(3);
    chk("enable", en, 32'h1);
    ce <= 1'b1;
    tick(3);
    chk("enable", en, 32'h0);
    $display("test continue and irq done");
    // nonzero retry restarts; a new retry code waits for off then on
    wr(OFS_RESP_BASE, 32'h48);
    start;
    pulse(4'h8);
    chk("enable", en, 32'h0);
    rd(OFS_CHAN_STATE, 32'h3);
    // ten timebase pin edges stand in for ten ticks of the retry delay
    repeat (10) begin
      sync <= 1'b1;
      @(posedge clk_i);
      sync <= 1'b0;
      @(posedge clk_i);
    end
    wait_en(1'b1, 8);
    tick(10);
    wr(OFS_RESP_BASE, 32'h40);
    pulse(4'h8);
    rd(OFS_CHAN_STATE, 32'h3);
    bias <= 1'b0; // losing bias ends the retries
    tick(3);
    rd(OFS_CHAN_STATE, 32'h0);
    pin <= 1'b0;
    bias <= 1'b1;
    wr(OFS_RESP_BASE, 32'h0);
    wr(OFS_CTRL, 32'h3);
    $display("test retry done");
    // start-up guarded by the turn-on timeout against a shorted output
    slow <= 1'b1;
    wr(OFS_RESP_BASE + 8'h10, 32'h80);
    pin <= 1'b1;
    wait_en(1'b1, 20);
    tick(8 * 400);
    chk("enable", en, 32'h1);
    wait_en(1'b0, 1200);
    chk("alert", alert_n, 32'h0);
    rd(OFS_CHAN_STATE, 32'h4);
    rd(OFS_STATUS_WORD, 32'h8041);
    rd(OFS_STATUS_DETAIL, 32'h4);
    $display("test turn-on timeout done");
    tick(2);
    results;
  end
endmodule
